// ==== mem_access_pkg.sv ====
package mem_access_pkg;

    // ********************************************************************
    // Address map.
    // ********************************************************************
    localparam logic [23:0] RAM_BASE        = 24'h000000;
    localparam logic [23:0] RAM_LAST        = 24'h000FFF;
    localparam logic [23:0] FLASH_BASE      = 24'h008000;
    localparam logic [23:0] FLASH_LAST      = 24'h017FFF;
    localparam logic [23:0] DRAM_BASE       = 24'h080000;
    localparam logic [23:0] DRAM_LAST       = 24'h08055F;
    localparam logic [23:0] FLASH_WAIT_ADDR = 24'h005320;
    localparam logic [23:0] DRAM_WAIT_ADDR  = 24'h005321;
    localparam logic [23:0] WP_WORD_ADDR    = 24'h017FFC;
    localparam logic [23:0] RP_WORD_ADDR    = 24'h017FFE;

    // ********************************************************************
    // Storage sizes in bytes and region geometry.
    // ********************************************************************
    localparam int RAM_BYTES    = 4096;
    localparam int FLASH_BYTES  = 65536;
    localparam int DRAM_BYTES   = 576;
    localparam int REGION_SHIFT = 14;
    localparam int REGION_COUNT = 4;

    // ********************************************************************
    // Register fields and reset values.
    // ********************************************************************
    localparam logic [2:0] FLASH_CYC_RESET = 3'h3;
    localparam logic [1:0] DRAM_CYC_RESET  = 2'h3;
    localparam logic [2:0] FLASH_CYC_ONE   = 3'h4;
    localparam logic [3:0] PROTECT_ERASED  = 4'hF;

    // Access sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_DONE = 4'b0100,
        ST_NEXT = 4'b1000
    } acc_state_t;

endpackage

// ==== mem_access_ctrl.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Flash split into 16K regions, per-region protection.
// - Protected data reads return zero.
// - Instruction fetches ignore read protection.
// - Protect bit zero means protected.
// - Write-protect word bits D0-D3 cover regions.
// - Read-protect word bits D1-D3; lowest region none.
// - Flash read cycles from 3-bit code.
// - Flash cycle field at 0x5320, reset 0x3.
// - Internal RAM 4K, one cycle access.
// - Display RAM 576 bytes, byte device, 2-5 cycles.
// - Display RAM usable as general memory.
// - Display RAM cycles from 2-bit code.
// - Display RAM field at 0x5321, reset 0x3.
// - Byte device splits wide access per byte.
// - Fetch waits for flash or display data access.
module mem_access_ctrl
    import mem_access_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        req_i,
    input  wire logic        fetch_i,
    input  wire logic        wr_i,
    input  wire logic [1:0]  size_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o,
    output logic             ready_o
);

    // ********************************************************************
    // Storage and configuration.
    // ********************************************************************
    // The display window spans more addresses than its byte count, so the
    // storage covers every decoded address and none aliases another.
    localparam int DRAM_SPAN = int'(DRAM_LAST - DRAM_BASE) + 1;

    logic [7:0]  ram_ff   [RAM_BYTES];
    logic [7:0]  flash_ff [FLASH_BYTES];
    logic [7:0]  dram_ff  [DRAM_SPAN];
    logic [2:0]  flash_cyc_ff;
    logic [2:0]  nxt_flash_cyc;
    logic [1:0]  dram_cyc_ff;
    logic [1:0]  nxt_dram_cyc;
    acc_state_t  state_ff;
    acc_state_t  nxt_state;
    logic [2:0]  cnt_ff;
    logic [2:0]  nxt_cnt;
    logic        byte1_ff;
    logic        nxt_byte1;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic        ready_ff;
    logic        nxt_ready;
    logic [2:0]  target;
    logic        hit_ram;
    logic        hit_flash;
    logic        hit_dram;
    logic [1:0]  region;
    logic        wr_prot;
    logic        rd_prot;
    logic [3:0]  wp_ff;
    logic [3:0]  nxt_wp;
    logic [3:0]  rp_ff;
    logic [3:0]  nxt_rp;
    logic [7:0]  low_ff;
    logic [7:0]  nxt_low;

    // Flash read cycle code to cycle count; reserved codes take five.
    function automatic logic [2:0] flash_cycles(input logic [2:0] code);
        case (code)
            3'h0:    flash_cycles = 3'h2;
            3'h1:    flash_cycles = 3'h3;
            3'h2:    flash_cycles = 3'h4;
            3'h4:    flash_cycles = 3'h1;
            default: flash_cycles = 3'h5;
        endcase
    endfunction

    // Window decode shared by all paths.
    function automatic logic in_range(input logic [23:0] a,
                                      input logic [23:0] lo,
                                      input logic [23:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // ********************************************************************
    // Decode and protection lookup.
    // ********************************************************************
    always_comb begin
        hit_ram   = in_range(addr_i, RAM_BASE, RAM_LAST);
        hit_flash = in_range(addr_i, FLASH_BASE, FLASH_LAST);
        hit_dram  = in_range(addr_i, DRAM_BASE, DRAM_LAST);
        region    = 2'((addr_i - FLASH_BASE) >> REGION_SHIFT);
        // Protect bits live in shadow registers that come up erased.
        // Zero bit protects; lowest region has no read control.
        wr_prot   = ~wp_ff[region];
        rd_prot   = (region != 2'h0) && ~rp_ff[region];
        if (hit_dram) begin
            target = 3'(dram_cyc_ff) + 3'h2;
        end else if (hit_flash && !wr_i) begin
            target = flash_cycles(flash_cyc_ff);
        end else begin
            target = 3'h1;
        end
    end

    // ********************************************************************
    // Access sequencer: counts wait cycles, one pass per byte for wide display accesses.
    // Fetch and data share this single port, so a fetch waits behind data.
    // ********************************************************************
    always_comb begin
        logic [23:0] a;
        logic [7:0]  dbyte;
        a             = addr_i + 24'(byte1_ff);
        dbyte         = dram_ff[11'(a - DRAM_BASE)];
        nxt_wp        = wp_ff;
        nxt_rp        = rp_ff;
        nxt_low       = low_ff;
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff;
        nxt_byte1     = byte1_ff;
        nxt_rdata     = rdata_ff;
        nxt_ready     = 1'b0;
        nxt_flash_cyc = flash_cyc_ff;
        nxt_dram_cyc  = dram_cyc_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_byte1 = 1'b0;
                if (req_i) begin
                    nxt_cnt   = 3'h1;
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cnt_ff >= target) begin
                    nxt_state = ST_DONE;
                end else begin
                    nxt_cnt = cnt_ff + 3'h1;
                end
            end
            ST_DONE: begin
                if (!wr_i) begin
                    // A wide display read parks its low byte until the
                    // second pass, so read data only moves on completion.
                    if (hit_dram) begin
                        if (byte1_ff) begin
                            nxt_rdata = {dbyte, low_ff};
                        end else if (size_i != 2'h0) begin
                            nxt_low = dbyte;
                        end else begin
                            nxt_rdata = {8'h00, dbyte};
                        end
                    end else if (hit_flash) begin
                        if (rd_prot && !fetch_i) begin
                            nxt_rdata = 16'h0000;
                        end else begin
                            nxt_rdata = {flash_ff[16'(a - FLASH_BASE) + 16'h1],
                                         flash_ff[16'(a - FLASH_BASE)]};
                        end
                    end else if (hit_ram) begin
                        nxt_rdata = {ram_ff[12'(a) + 12'h1], ram_ff[12'(a)]};
                    end else if (addr_i == FLASH_WAIT_ADDR) begin
                        nxt_rdata = {13'h0000, flash_cyc_ff};
                    end else if (addr_i == DRAM_WAIT_ADDR) begin
                        nxt_rdata = {14'h0000, dram_cyc_ff};
                    end else begin
                        nxt_rdata = 16'h0000;
                    end
                end else if (addr_i == FLASH_WAIT_ADDR) begin
                    nxt_flash_cyc = wdata_i[2:0];
                end else if (addr_i == DRAM_WAIT_ADDR) begin
                    nxt_dram_cyc = wdata_i[1:0];
                end else if (hit_flash && !wr_prot) begin
                    // A stored protect word takes effect at once.
                    if (addr_i == WP_WORD_ADDR) nxt_wp = wdata_i[3:0];
                    if (addr_i == RP_WORD_ADDR) nxt_rp = wdata_i[3:0];
                end
                if (hit_dram && size_i != 2'h0 && !byte1_ff) begin
                    nxt_byte1 = 1'b1;
                    nxt_cnt   = 3'h1;
                    nxt_state = ST_WAIT;
                end else begin
                    nxt_ready = 1'b1;
                    nxt_state = ST_NEXT;
                end
            end
            ST_NEXT: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Registers for the sequencer and configuration.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff     <= ST_IDLE;
            cnt_ff       <= 3'h0;
            byte1_ff     <= 1'b0;
            rdata_ff     <= 16'h0000;
            ready_ff     <= 1'b0;
            flash_cyc_ff <= FLASH_CYC_RESET;
            dram_cyc_ff  <= DRAM_CYC_RESET;
            wp_ff        <= PROTECT_ERASED;
            rp_ff        <= PROTECT_ERASED;
            low_ff       <= 8'h00;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            byte1_ff     <= nxt_byte1;
            rdata_ff     <= nxt_rdata;
            ready_ff     <= nxt_ready;
            flash_cyc_ff <= nxt_flash_cyc;
            dram_cyc_ff  <= nxt_dram_cyc;
            wp_ff        <= nxt_wp;
            rp_ff        <= nxt_rp;
            low_ff       <= nxt_low;
        end
    end

    // Memory writes; flash writes blocked in write-protected regions.
    always_ff @(posedge clk_i) begin
        if (state_ff == ST_DONE && wr_i) begin
            if (hit_ram) begin
                ram_ff[12'(addr_i)] <= wdata_i[7:0];
                if (size_i != 2'h0) ram_ff[12'(addr_i) + 12'h1] <= wdata_i[15:8];
            end else if (hit_dram) begin
                dram_ff[11'(addr_i - DRAM_BASE) + 11'(byte1_ff)] <=
                    byte1_ff ? wdata_i[15:8] : wdata_i[7:0];
            end else if (hit_flash && !wr_prot) begin
                flash_ff[16'(addr_i - FLASH_BASE)] <= wdata_i[7:0];
                flash_ff[16'(addr_i - FLASH_BASE) + 16'h1] <= wdata_i[15:8];
            end
        end
    end

    assign rdata_o = rdata_ff;
    assign ready_o = ready_ff;

endmodule // mem_access_ctrl

// ==== mem_access_ctrl_properties.sv ====
`timescale 1ns/100ps
// ********************************************************************
// Completion timing and register readback checks.
// ********************************************************************
module mem_access_ctrl_properties
    import mem_access_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        req_i,
    input wire logic        fetch_i,
    input wire logic        wr_i,
    input wire logic [1:0]  size_i,
    input wire logic [23:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] rdata_o,
    input wire logic        ready_o
);
    logic        busy_ff, rdy_ff, rd_ff, byte_ff, start;
    logic [23:0] a_ff;
    logic [2:0]  fc_ff;
    logic [1:0]  dc_ff;
    logic [4:0]  cnt_ff;
    int          tgt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    assign start = req_i && !busy_ff && !rdy_ff;
    // Tracks the open access, its cycle count and the wait settings.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {busy_ff, rdy_ff, rd_ff, byte_ff, a_ff, cnt_ff} <= '0;
            fc_ff <= 3'h3;
            dc_ff <= 2'h3;
        end else begin
            rdy_ff <= ready_o;
            if (start) begin
                {busy_ff, cnt_ff, a_ff} <= {1'b1, 5'h01, addr_i};
                {rd_ff, byte_ff} <= {!wr_i, size_i == 2'h0};
                if (wr_i && addr_i == FLASH_WAIT_ADDR) fc_ff <= wdata_i[2:0];
                if (wr_i && addr_i == DRAM_WAIT_ADDR) dc_ff <= wdata_i[1:0];
            end else if (ready_o) busy_ff <= 1'b0;
            else if (busy_ff) cnt_ff <= cnt_ff + 5'h01;
        end
    end
    // Expected wait count of the open access, zero where not fixed.
    always_comb begin
        tgt = 0;
        if (a_ff <= RAM_LAST || a_ff == FLASH_WAIT_ADDR) tgt = 1;
        if (a_ff == DRAM_WAIT_ADDR) tgt = 1;
        if (rd_ff && a_ff >= FLASH_BASE && a_ff <= FLASH_LAST)
            tgt = (fc_ff < 3'h4) ? 2 + fc_ff : (fc_ff == 3'h4) ? 1 : 5;
        if (byte_ff && a_ff >= DRAM_BASE && a_ff <= DRAM_LAST) tgt = 2 + dc_ff;
    end
    sequence s_ram_wait;
        !ready_o [*2] ##1 ready_o;
    endsequence
    property p_ram_lat;
        start && addr_i <= RAM_LAST |-> ##1 s_ram_wait;
    endproperty
    a_ram_lat: assert property (p_ram_lat) else $error("ram latency");
    property p_lat;
        ready_o && tgt != 0 |-> cnt_ff == 5'(tgt + 2);
    endproperty
    a_lat: assert property (p_lat) else $error("wait count");
    property p_hold;
        busy_ff && tgt != 0 && cnt_ff < 5'(tgt + 2) |-> !ready_o;
    endproperty
    a_hold: assert property (p_hold) else $error("early ready");
    property p_pulse;
        ready_o |=> !ready_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_idle;
        !busy_ff |-> !ready_o;
    endproperty
    a_idle: assert property (p_idle) else $error("stray ready");
    property p_fcfg;
        ready_o && rd_ff && a_ff == FLASH_WAIT_ADDR |-> rdata_o == {13'h0, fc_ff};
    endproperty
    a_fcfg: assert property (p_fcfg) else $error("flash cfg read");
    property p_dcfg;
        ready_o && rd_ff && a_ff == DRAM_WAIT_ADDR |-> rdata_o == {14'h0, dc_ff};
    endproperty
    a_dcfg: assert property (p_dcfg) else $error("dram cfg read");
    property p_rdata;
        $changed(rdata_o) |-> ready_o && rd_ff;
    endproperty
    a_rdata: assert property (p_rdata) else $error("rdata moved");
endmodule // mem_access_ctrl_properties

bind mem_access_ctrl mem_access_ctrl_properties i_props (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .fetch_i(fetch_i),
    .wr_i(wr_i), .size_i(size_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .ready_o(ready_o));

// ==== cpu_bus_model.sv ====
`timescale 1ns/100ps
// ********************************************************************
// Core bus master: one access at a time, held until ready.
// ********************************************************************
module cpu_bus_model (
    input  wire logic        clk_i,
    input  wire logic        ready_i,
    input  wire logic [15:0] rdata_i,
    output logic             req_o,
    output logic             fetch_o,
    output logic             wr_o,
    output logic [1:0]       size_o,
    output logic [23:0]      addr_o,
    output logic [15:0]      wdata_o,
    output logic             hung_o
);
    // Bus starts released.
    initial begin
        {req_o, fetch_o, wr_o, size_o, addr_o, wdata_o, hung_o} = '0;
    end
    // A fetch never overlaps a data access: it waits for ready.
    task automatic access(input logic f, w, input logic [1:0] sz,
        input logic [23:0] a, input logic [15:0] wd,
        output logic [15:0] rd, output int cyc);
        @(negedge clk_i);
        {fetch_o, wr_o, size_o, addr_o, wdata_o} = {f, w, sz, a, wd};
        req_o = 1'b1;
        cyc = 0;
        do begin
            @(negedge clk_i);
            cyc++;
        end while (ready_i !== 1'b1 && cyc < 40);
        rd = rdata_i;
        hung_o = (ready_i !== 1'b1);
        req_o = 1'b0;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
        @(negedge clk_i);
    endtask
endmodule // cpu_bus_model

// ==== tb_mem_access_ctrl.sv ====
`timescale 1ns/100ps
// ********************************************************************
// Access sequences against the protection and wait settings.
// ********************************************************************
module tb_mem_access_ctrl;
    import mem_access_pkg::*;
    logic        clk_i, sys_rst_i, req, fetch, wr, ready, hung;
    logic [1:0]  size;
    logic [23:0] addr;
    logic [15:0] wdata, rdata, rd;
    int          n_errors = 0, compares = 0, cyc;
    int          fl[6] = '{2, 3, 4, 5, 1, 5};
    mem_access_ctrl i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .req_i(req), .fetch_i(fetch), .wr_i(wr), .size_i(size),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .ready_o(ready));
    cpu_bus_model i_cpu (.clk_i(clk_i), .ready_i(ready), .rdata_i(rdata),
        .req_o(req), .fetch_o(fetch), .wr_o(wr), .size_o(size),
        .addr_o(addr), .wdata_o(wdata), .hung_o(hung));
    // Clock at 40 MHz.
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic check(input string what, input logic [15:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic acc(input logic f, w, input logic [1:0] sz,
                       input logic [23:0] a, input logic [15:0] wd);
        i_cpu.access(f, w, sz, a, wd, rd, cyc);
        if (hung) begin
            n_errors++;
            report_and_stop();
        end
    endtask
    // Main sequence.
    initial begin
        sys_rst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        sys_rst_i = 1'b0;
        acc(0, 0, 2'h0, FLASH_WAIT_ADDR, 16'h0);
        check("flash wait reset", 16'h0003, rd);
        acc(0, 0, 2'h0, DRAM_WAIT_ADDR, 16'h0);
        check("dram wait reset", 16'h0003, rd);
        acc(0, 1, 2'h1, 24'h000FBE, 16'hA55A);
        acc(0, 0, 2'h1, 24'h000FBE, 16'h0);
        check("ram data", 16'hA55A, rd);
        check("ram cycles", 16'h0003, 16'(cyc));
        acc(0, 1, 2'h1, 24'h00C000, 16'h1234);
        acc(0, 1, 2'h1, 24'h010000, 16'h5678);
        acc(0, 1, 2'h1, WP_WORD_ADDR, 16'hFFFD);
        acc(0, 1, 2'h1, RP_WORD_ADDR, 16'hFFFB);
        acc(0, 1, 2'h1, 24'h00C000, 16'hAAAA);
        acc(0, 0, 2'h1, 24'h00C000, 16'h0);
        check("write protected", 16'h1234, rd);
        acc(0, 0, 2'h1, 24'h010000, 16'h0);
        check("read protected", 16'h0000, rd);
        acc(1, 0, 2'h1, 24'h010000, 16'h0);
        check("fetch protected", 16'h5678, rd);
        for (int c = 0; c < 6; c++) begin
            acc(0, 1, 2'h0, FLASH_WAIT_ADDR, 16'h00F8 | 16'(c));
            acc(0, 0, 2'h0, FLASH_WAIT_ADDR, 16'h0);
            check("flash wait code", 16'(c), rd);
            acc(1, 0, 2'h1, 24'h010000, 16'h0);
            check("flash cycles", 16'(fl[c] + 2), 16'(cyc));
        end
        for (int c = 0; c < 4; c++) begin
            acc(0, 1, 2'h0, DRAM_WAIT_ADDR, 16'h00FC | 16'(c));
            acc(0, 0, 2'h0, DRAM_WAIT_ADDR, 16'h0);
            check("dram wait code", 16'(c), rd);
            acc(0, 1, 2'h0, DRAM_BASE + 24'(c), 16'(8'h30 + c));
            acc(0, 0, 2'h0, DRAM_BASE + 24'(c), 16'h0);
            check("dram byte", 16'(8'h30 + c), {8'h00, rd[7:0]});
            check("dram cycles", 16'(2 + c + 2), 16'(cyc));
        end
        acc(0, 1, 2'h1, DRAM_LAST - 24'h1, 16'hBEEF);
        acc(0, 0, 2'h1, DRAM_LAST - 24'h1, 16'h0);
        check("dram word", 16'hBEEF, rd);
        check("dram word cycles", 16'h000D, 16'(cyc));
        report_and_stop();
    end
endmodule // tb_mem_access_ctrl
